// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the power-down and loop mode control block
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Each stimulus change is settled before checking, so the bench can track
//        the reference that holdover and free-run keep on o_active_ref
`timescale 1ns/10ps

module tb_top;
    import pd_loop_pkg::*;

    // ***************************************************************
    // Signals and design instance
    // ***************************************************************
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [NUM_REFS-1:0] i_ref_valid = 4'hf;
    logic [DATA_W-1:0] o_rdata;
    sleep_ctrl_type o_ctrl;
    loop_state_type o_loop_state;
    ref_id_type o_active_ref;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 97729;
    int cycles = 0;
    logic [7:0] pd_val = 8'h00;
    logic [7:0] lp_val = 8'h00;
    logic [1:0] last_ref = 2'b00;

    power_down_and_loop_mode_control uut (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_ref_valid(i_ref_valid),
        .o_ctrl(o_ctrl),
        .o_loop_state(o_loop_state),
        .o_active_ref(o_active_ref)
    );

    always #50 i_sys_clk = ~i_sys_clk;

    // ***************************************************************
    // Expectation functions
    // ***************************************************************
    // Returns {state, ref}; the reference is kept from the last tracking state
    function automatic logic [3:0] loop_model(input logic [7:0] pd, input logic [7:0] lp,
                                              input logic [3:0] v, input logic [1:0] last);
        logic [1:0] u;
        logic [1:0] a;
        logic [3:0] auto_res;
        u = lp[1:0];
        a = v[0] ? 2'b00 : v[1] ? 2'b01 : v[2] ? 2'b10 : 2'b11;
        auto_res = (|v) ? {2'b00, a} : {2'b01, last};
        if (pd[7]) return 4'h0;
        if (lp[5]) return {2'b11, last};
        if (lp[6]) return {2'b01, last};
        case (lp[4:3])
            2'b00: return auto_res;
            2'b01: return v[u] ? {2'b00, u} : auto_res;
            2'b10: return v[u] ? {2'b00, u} : {2'b01, last};
            default: return {2'b00, u};
        endcase
    endfunction

    function automatic logic [7:0] ctrl_model(input logic [7:0] pd);
        return {1'b0, pd[7], pd[5] | pd[0], pd[4] | pd[0], pd[3] | pd[0],
                pd[2] | pd[0], pd[1] | pd[0], pd[0]};
    endfunction

    // ***************************************************************
    // Bus tasks and comparison
    // ***************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        if (a == PD_CTRL_ADDR) pd_val = d & 8'hbf;
        if (a == LOOP_CTRL_ADDR) lp_val = d & 8'h7b;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
        @(posedge i_sys_clk);
        #1;
        check(o_rdata, 8'h00);
    endtask

    // Let a change reach the outputs, then compare outputs, registers and status
    task automatic settle;
        logic [3:0] e;
        repeat (3) @(posedge i_sys_clk);
        #1;
        e = loop_model(pd_val, lp_val, i_ref_valid, last_ref);
        last_ref = e[1:0];
        check({1'b0, o_ctrl}, ctrl_model(pd_val));
        check({6'h0, o_loop_state}, {6'h0, e[3:2]});
        check({6'h0, o_active_ref}, {6'h0, e[1:0]});
        rd(PD_CTRL_ADDR, pd_val);
        rd(LOOP_CTRL_ADDR, lp_val);
        rd(LOOP_STATUS_ADDR, {4'h0, e});
    endtask

    task automatic setv(input logic [3:0] nv);
        @(posedge i_sys_clk);
        i_ref_valid <= nv;
        settle();
    endtask

    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Expected run is a few thousand cycles; the ceiling leaves ample slack
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        logic [31:0] r;
        logic [3:0] vv [3];
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        check({1'b0, o_ctrl}, 8'h00);
        settle();
        rd(12'ha02, 8'h00);
        wr(12'ha02, 8'hff);
        wr(LOOP_STATUS_ADDR, 8'hff);
        settle();
        for (int i = 0; i < 8; i++) begin
            wr(PD_CTRL_ADDR, 8'h01 << i);
            settle();
        end
        wr(PD_CTRL_ADDR, 8'h00);
        for (int m = 0; m < 4; m++) begin
            for (int u = 0; u < 4; u++) begin
                vv[0] = 4'hf;
                vv[1] = 4'hf & ~(4'h1 << u);
                vv[2] = 4'h0;
                wr(LOOP_CTRL_ADDR, {3'b000, m[1:0], 1'b0, u[1:0]});
                for (int k = 0; k < 3; k++) setv(vv[k]);
            end
        end
        setv(4'hc);
        foreach (vv[k]) begin
            wr(LOOP_CTRL_ADDR, 8'h60 >> k);
            settle();
        end
        wr(LOOP_CTRL_ADDR, 8'h1a);
        settle();
        wr(PD_CTRL_ADDR, 8'h80);
        settle();
        wr(PD_CTRL_ADDR, 8'h00);
        settle();
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= LOOP_CTRL_ADDR;
        i_wdata <= 8'h4b;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        lp_val = 8'h4b;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, 8'h4b);
        settle();
        repeat (120) begin
            r = $random(seed);
            case (r[9:8])
                2'b00: wr(PD_CTRL_ADDR, r[7:0]);
                2'b11: begin
                    @(posedge i_sys_clk);
                    i_ref_valid <= r[3:0];
                end
                default: wr(LOOP_CTRL_ADDR, r[7:0] & 8'hfb);
            endcase
            settle();
        end
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        pd_val = 8'h00;
        lp_val = 8'h00;
        last_ref = 2'b00;
        settle();
        wrap_up();
    end

endmodule

// *** verilog/pd_loop_pkg.sv ***
// Purpose: Shared constants and types for the power-down and loop mode block
// Assumes: 12-bit register address, 8-bit register data
// Notes: Status register offset sits outside the control range on purpose
package pd_loop_pkg;

    // ***************************************************************
    // Register offsets
    // ***************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] PD_CTRL_ADDR = 12'ha00;
    localparam logic [11:0] LOOP_CTRL_ADDR = 12'ha01;
    localparam logic [11:0] LOOP_STATUS_ADDR = 12'hbf0;

    // ***************************************************************
    // Power-down control fields
    // ***************************************************************
    localparam int PD_SOFT_RST_BIT = 7;
    localparam int PD_SYS_CLK_BIT = 5;
    localparam int PD_REF_BIT = 4;
    localparam int PD_TDC_BIT = 3;
    localparam int PD_DAC_BIT = 2;
    localparam int PD_DIST_BIT = 1;
    localparam int PD_FULL_BIT = 0;
    localparam logic [7:0] PD_WRITE_MASK = 8'hbf;
    localparam logic [7:0] PD_RESET_VALUE = 8'h00;

    // ***************************************************************
    // Loop mode control fields
    // ***************************************************************
    localparam int LOOP_HOLD_BIT = 6;
    localparam int LOOP_FREE_BIT = 5;
    localparam int LOOP_SEL_LSB = 3;
    localparam int LOOP_REF_LSB = 0;
    localparam logic [7:0] LOOP_WRITE_MASK = 8'h7b;
    localparam logic [7:0] LOOP_RESET_VALUE = 8'h00;

    // ***************************************************************
    // Status fields
    // ***************************************************************
    localparam int STAT_REF_LSB = 0;
    localparam int STAT_STATE_LSB = 2;
    localparam int NUM_REFS = 4;

    typedef enum logic [1:0] {
        SEL_AUTO = 2'b00,
        SEL_FALLBACK = 2'b01,
        SEL_HOLD = 2'b10,
        SEL_MANUAL = 2'b11
    } sel_mode_type;

    typedef enum logic [1:0] {
        REF_A = 2'b00,
        REF_AA = 2'b01,
        REF_B = 2'b10,
        REF_BB = 2'b11
    } ref_id_type;

    typedef enum logic [1:0] {
        ST_TRACK = 2'b00,
        ST_HOLDOVER = 2'b01,
        ST_FREE_RUN = 2'b11
    } loop_state_type;

    typedef struct packed {
        logic core_reset;
        logic sys_clock_sleep;
        logic ref_sleep;
        logic time_converter_sleep;
        logic dac_sleep;
        logic dist_sleep;
        logic full_sleep;
    } sleep_ctrl_type;

endpackage

// *** verilog/power_down_and_loop_mode_control.sv ***
// Purpose: Power-down and loop mode control registers with reference selection
// Assumes: Single clock, synchronous register port, reference valid flags in sync
// Notes: Control outputs follow a register write by one clock
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

module power_down_and_loop_mode_control
    import pd_loop_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // Reference monitor
    input wire logic [NUM_REFS-1:0] i_ref_valid,
    // Control outputs
    output sleep_ctrl_type o_ctrl,
    output loop_state_type o_loop_state,
    output ref_id_type o_active_ref
);

    // ***************************************************************
    // Register file
    // ***************************************************************
    logic [DATA_W-1:0] pd_reg;
    logic [DATA_W-1:0] loop_reg;
    logic [DATA_W-1:0] rdata_next;
    logic soft_rst;
    logic force_hold;
    logic force_free;
    sel_mode_type sel_mode;
    ref_id_type user_ref;

    // Unused bits are masked so they always read back as zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pd_reg <= PD_RESET_VALUE;
        end else if (i_wr && i_addr == PD_CTRL_ADDR) begin
            pd_reg <= i_wdata & PD_WRITE_MASK;
        end
    end

    // Soft reset leaves this register untouched
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            loop_reg <= LOOP_RESET_VALUE;
        end else if (i_wr && i_addr == LOOP_CTRL_ADDR) begin
            loop_reg <= i_wdata & LOOP_WRITE_MASK;
        end
    end

    assign soft_rst = pd_reg[PD_SOFT_RST_BIT];
    assign force_hold = loop_reg[LOOP_HOLD_BIT];
    assign force_free = loop_reg[LOOP_FREE_BIT];
    assign sel_mode = sel_mode_type'(loop_reg[LOOP_SEL_LSB +: 2]);
    assign user_ref = ref_id_type'(loop_reg[LOOP_REF_LSB +: 2]);

    always_comb begin
        rdata_next = '0;
        if (i_rd) begin
            unique case (i_addr)
                PD_CTRL_ADDR: begin
                    rdata_next = pd_reg;
                end
                LOOP_CTRL_ADDR: begin
                    rdata_next = loop_reg;
                end
                LOOP_STATUS_ADDR: begin
                    rdata_next[STAT_REF_LSB +: 2] = o_active_ref;
                    rdata_next[STAT_STATE_LSB +: 2] = o_loop_state;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // Read data only stands in the cycle after the strobe
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    // ***************************************************************
    // Power-down controls
    // ***************************************************************
    sleep_ctrl_type ctrl_next;

    // Full power-down drives every block to sleep, not only its own flag
    always_comb begin
        ctrl_next.core_reset = soft_rst;
        ctrl_next.sys_clock_sleep = pd_reg[PD_SYS_CLK_BIT] | pd_reg[PD_FULL_BIT];
        ctrl_next.ref_sleep = pd_reg[PD_REF_BIT] | pd_reg[PD_FULL_BIT];
        ctrl_next.time_converter_sleep = pd_reg[PD_TDC_BIT] | pd_reg[PD_FULL_BIT];
        ctrl_next.dac_sleep = pd_reg[PD_DAC_BIT] | pd_reg[PD_FULL_BIT];
        ctrl_next.dist_sleep = pd_reg[PD_DIST_BIT] | pd_reg[PD_FULL_BIT];
        ctrl_next.full_sleep = pd_reg[PD_FULL_BIT];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl <= '0;
        end else begin
            o_ctrl <= ctrl_next;
        end
    end

    // ***************************************************************
    // Reference selection
    // ***************************************************************
    logic [NUM_REFS-1:0] eff_valid;
    logic auto_found;
    ref_id_type auto_ref;
    logic use_ref;
    ref_id_type pick_ref;
    loop_state_type state_next;

    // Forced holdover looks like every reference faulted
    assign eff_valid = force_hold ? '0 : i_ref_valid;

    // Fixed priority A, AA, B, BB; lowest code wins
    always_comb begin
        auto_found = 1'b0;
        auto_ref = REF_A;
        for (int i = NUM_REFS - 1; i >= 0; i--) begin
            if (eff_valid[i]) begin
                auto_found = 1'b1;
                auto_ref = ref_id_type'(i[1:0]);
            end
        end
    end

    always_comb begin
        use_ref = 1'b0;
        pick_ref = REF_A;
        unique case (sel_mode)
            SEL_AUTO: begin
                use_ref = auto_found;
                pick_ref = auto_ref;
            end
            SEL_FALLBACK: begin
                if (eff_valid[user_ref]) begin
                    use_ref = 1'b1;
                    pick_ref = user_ref;
                end else begin
                    use_ref = auto_found;
                    pick_ref = auto_ref;
                end
            end
            SEL_HOLD: begin
                use_ref = eff_valid[user_ref];
                pick_ref = user_ref;
            end
            SEL_MANUAL: begin
                // Only a forced holdover, forced free-run or soft reset overrides manual choice
                use_ref = ~force_hold;
                pick_ref = user_ref;
            end
        endcase
    end

    // Free-run is checked first so it overrides holdover
    always_comb begin
        if (force_free) begin
            state_next = ST_FREE_RUN;
        end else if (!use_ref) begin
            state_next = ST_HOLDOVER;
        end else begin
            state_next = ST_TRACK;
        end
    end

    // ***************************************************************
    // Loop state and active reference
    // ***************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_loop_state <= ST_TRACK;
        end else if (soft_rst) begin
            o_loop_state <= ST_TRACK;
        end else begin
            unique case (o_loop_state)
                ST_TRACK, ST_HOLDOVER, ST_FREE_RUN: begin
                    o_loop_state <= state_next;
                end
                default: begin
                    o_loop_state <= ST_TRACK;
                end
            endcase
        end
    end

    // The last reference is kept through holdover and free-run
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_active_ref <= REF_A;
        end else if (soft_rst) begin
            o_active_ref <= REF_A;
        end else if (state_next == ST_TRACK) begin
            o_active_ref <= pick_ref;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    a_soft_reset_core: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        soft_rst |=> o_ctrl.core_reset && o_loop_state == ST_TRACK)
        else $error("soft reset did not hold the core");

    a_soft_reset_keep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        soft_rst && !i_wr |=> $stable(loop_reg))
        else $error("soft reset disturbed loop register");

    a_sys_clock_sleep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_wr && i_addr == PD_CTRL_ADDR
        ##1 !(i_wr && i_addr == PD_CTRL_ADDR)
        |=> o_ctrl.sys_clock_sleep ==
            ($past(i_wdata[PD_SYS_CLK_BIT], 2) | $past(i_wdata[PD_FULL_BIT], 2)))
        else $error("system clock sleep mismatch");

    a_ref_sleep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        1'b1 |=> o_ctrl.ref_sleep == ($past(pd_reg[PD_REF_BIT]) | $past(pd_reg[PD_FULL_BIT])))
        else $error("reference sleep mismatch");

    a_converter_sleep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(pd_reg[PD_TDC_BIT]) |-> ##1 o_ctrl.time_converter_sleep)
        else $error("time converter did not sleep");

    a_dac_sleep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !pd_reg[PD_DAC_BIT] && !pd_reg[PD_FULL_BIT] |=> !o_ctrl.dac_sleep)
        else $error("DAC asleep without cause");

    a_dist_sleep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        pd_reg[PD_DIST_BIT] |=> o_ctrl.dist_sleep)
        else $error("distribution outputs not asleep");

    a_full_sleep_all: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        pd_reg[PD_FULL_BIT] |=> o_ctrl.full_sleep && o_ctrl.dac_sleep
            && o_ctrl.sys_clock_sleep && o_ctrl.ref_sleep
            && o_ctrl.time_converter_sleep && o_ctrl.dist_sleep)
        else $error("full power-down left a block awake");

    a_forced_holdover: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        force_hold && !force_free && !soft_rst |=> o_loop_state == ST_HOLDOVER)
        else $error("forced holdover not entered");

    a_free_run_wins: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        force_free && !soft_rst |=> o_loop_state == ST_FREE_RUN)
        else $error("free-run not entered");

    a_auto_priority: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode == SEL_AUTO && !force_hold && !force_free && !soft_rst
        && i_ref_valid[0]
        |=> o_active_ref == REF_A && o_loop_state == ST_TRACK)
        else $error("automatic mode ignored top priority reference");

    a_fallback_auto: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode == SEL_FALLBACK && !force_hold && !force_free && !soft_rst
        && !i_ref_valid[user_ref] && i_ref_valid != '0
        |=> o_loop_state == ST_TRACK && o_active_ref != $past(user_ref))
        else $error("fallback did not switch to automatic choice");

    a_hold_mode_fault: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode == SEL_HOLD && !force_free && !soft_rst && !i_ref_valid[user_ref]
        |=> o_loop_state == ST_HOLDOVER)
        else $error("holdover mode did not hold on fault");

    a_manual_keep: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode == SEL_MANUAL && !force_hold && !force_free && !soft_rst
        |=> o_loop_state == ST_TRACK && o_active_ref == $past(user_ref))
        else $error("manual mode left the user reference");

    a_unmapped_read: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_rd && i_addr != PD_CTRL_ADDR && i_addr != LOOP_CTRL_ADDR
        && i_addr != LOOP_STATUS_ADDR |=> o_rdata == '0)
        else $error("unmapped read returned data");

    a_reserved_zero: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_rd && i_addr == LOOP_CTRL_ADDR |=> o_rdata[7] == 1'b0 && o_rdata[2] == 1'b0)
        else $error("unused loop bits read nonzero");

    a_user_ref_track: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode != SEL_AUTO && !force_hold && !force_free && !soft_rst
        && i_ref_valid[user_ref]
        |=> o_loop_state == ST_TRACK && o_active_ref == $past(user_ref))
        else $error("valid user reference not taken");

    a_soft_reset_ref: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        soft_rst |=> o_active_ref == REF_A)
        else $error("soft reset did not return to the first reference");

    a_free_run_ref: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        force_free && !soft_rst |=> $stable(o_active_ref))
        else $error("free-run moved the active reference");

    a_holdover_ref: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        sel_mode == SEL_HOLD && !force_free && !soft_rst && !i_ref_valid[user_ref]
        |=> $stable(o_active_ref))
        else $error("holdover moved the active reference");

    a_read_idle_zero: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_rd |=> o_rdata == '0)
        else $error("read data stood without a read");

endmodule
